// ==== hdl/sar_regs.svh ====
// Register map, field positions, reset values and counts of the SAR control block.
// Assumes an 8-bit special function register bus with a 4-bit page select.
`ifndef SAR_REGS_SVH
`define SAR_REGS_SVH

`define SAR_PAGE_MAIN      4'h0
`define SAR_PAGE_FACTORY   4'hf
`define SAR_ADDR_CFG       8'hbc
`define SAR_ADDR_ACC       8'hba
`define SAR_ADDR_RES_HIGH  8'hbe
`define SAR_ADDR_RES_LOW   8'hbd
`define SAR_ADDR_TEMP_SENSOR_OFFSET_HIGH 8'hbe
`define SAR_ADDR_TEMP_SENSOR_OFFSET_LOW  8'hbd

`define SAR_CFG_8BIT_BIT   2
`define SAR_ACC_12BIT_BIT  7
`define SAR_ACC_RPT_MSB    2
`define SAR_ACC_RPT_LSB    0
`define SAR_CFG_RESET      8'h00
`define SAR_ACC_RESET      8'h00
`define SAR_TEMP_SENSOR_OFFSET_RESET     10'h000

`define SAR_MSB_PTR        4'h9
`define SAR_LAST_PTR_10    4'h0
`define SAR_LAST_PTR_8     4'h2
`define SAR_MAX_12BIT      16'hffc

`endif

// ==== hdl/sar_pkg.sv ====
// Types shared by the SAR control block.
// Assumes sar_regs.svh holds every number.
package sar_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DONE} sar_state_e;
	typedef logic [9:0] sar_code_t;
endpackage

// ==== hdl/sar_accum.sv ====
// Clearable adder that sums conversion codes of one burst.
// Assumes clear and add come from the sequencer on the same clock.
`timescale 1ns/1ps
module sar_accum #(
	parameter int W  = 16,
	parameter int IW = 10
) (
	// Clock and reset
	input  wire logic          ref_clk,
	input  wire logic          rst_b,
	// Control
	input  wire logic          clear,
	input  wire logic          add_en,
	input  wire logic [IW-1:0] add_val,
	// Sum
	output logic      [W-1:0]  sum
);
	logic [W-1:0] sum_q;
	logic [W-1:0] sum_d;

	if (W < IW) begin : g_chk
		$error("sar_accum: W narrower than IW");
	end

	always_comb begin
		sum_d = clear ? '0 : sum_q;
		if (add_en) begin
			sum_d = sum_d + W'(add_val);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			sum_q <= '0;
		end else begin
			sum_q <= sum_d;
		end
	end

	assign sum = sum_q;

	property p_clr;
		@(posedge ref_clk) disable iff (!rst_b)
		clear |=> sum_q == '0;
	endproperty
	a_clr: assert property (p_clr) else $error("accumulator not cleared");
endmodule

// ==== hdl/sar_ctrl.sv ====
// SAR converter sequencer, resolution modes, result and factory offset registers.
// Assumes sar_tick is a one-cycle pulse per SAR clock on ref_clk, comp_in is analogue.
//
// Functional notes
// - Eight-bit select makes each conversion resolve only the top eight bits.
// - Eight-bit conversions end two SAR clock cycles before ten-bit ones.
// - Eight-bit mode forces the two low bits to zero; low byte reads zero for eight-bit conversions outside twelve-bit mode.
// - Twelve-bit mode sums the repeat-field count of conversions (four for field 1) on four reference levels.
// - Element matching rotates the largest DAC elements per constituent conversion.
// - Twelve-bit sum lands in result high and low; peak value 4092 for a burst of four conversions.
// - In twelve-bit mode, repeats of 4, 8, 16, 32 or 64 accumulate into a wider sum.
// - Read-only ten-bit offset; upper eight bits at page 0xF address 0xBE.
// - Offset low byte holds two low bits in 7:6; 5:0 read zero.
`timescale 1ns/1ps
`include "sar_regs.svh"
module sar_ctrl import sar_pkg::*; #(
	parameter int ACC_W = 16
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// Register bus
	input  wire logic [3:0]  sfr_page,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	output logic      [7:0]  sfr_rdata,
	// Converter core
	input  wire logic        conv_start,
	input  wire logic        sar_tick,
	input  wire logic        comp_in,
	output logic      [9:0]  dac_code,
	output logic      [1:0]  ref_sel,
	output logic      [1:0]  dem_rot,
	output logic             conv_busy,
	output logic             conv_done,
	// Factory trim
	input  wire logic [9:0]  factory_offset
);
	if (ACC_W < 16 || ACC_W > 16) begin : g_chk
		$error("sar_ctrl: result registers hold exactly 16 bits");
	end

	sar_state_e  st_q, st_d;
	sar_code_t   trial_q, trial_d, code_q, code_d;
	logic [3:0]  ptr_q, ptr_d;
	logic [6:0]  idx_q, idx_d, len_q, len_d, conv_cnt_q;
	logic        m8_q, m8_d, m12_q, m12_d;
	logic [15:0] res_q, res_d;
	logic [7:0]  cfg_q, cfg_d, acc_q, acc_d, rdata_q, rdata_d;
	logic [9:0]  temp_sensor_offset_q, temp_sensor_offset_d;
	logic        temp_sensor_offset_ld_q, temp_sensor_offset_ld_d;
	logic        c1_q, c2_q, c3_q, comp_q, comp_d;
	logic        conv_end, acc_clr;
	logic [3:0]  last_ptr;
	logic [6:0]  burst_len;
	logic [ACC_W-1:0] acc_sum;
	sar_code_t   dec;

	// Comparator crosses from the analogue side; only agreeing samples count
	always_comb begin
		comp_d = (c2_q == c3_q) ? c3_q : comp_q;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			c1_q   <= 1'b0;
			c2_q   <= 1'b0;
			c3_q   <= 1'b0;
			comp_q <= 1'b0;
		end else begin
			c1_q   <= comp_in;
			c2_q   <= c1_q;
			c3_q   <= c2_q;
			comp_q <= comp_d;
		end
	end

	// Repeat field: 0 one conversion, then 4, 8, 16, 32, 64
	always_comb begin
		case (acc_q[`SAR_ACC_RPT_MSB:`SAR_ACC_RPT_LSB])
			3'h0:    burst_len = 7'h01;
			3'h1:    burst_len = 7'h04;
			3'h2:    burst_len = 7'h08;
			3'h3:    burst_len = 7'h10;
			3'h4:    burst_len = 7'h20;
			default: burst_len = 7'h40;
		endcase
	end

	assign last_ptr = m8_q ? `SAR_LAST_PTR_8 : `SAR_LAST_PTR_10;
	assign dec      = comp_q ? trial_q : (trial_q & ~(10'h001 << ptr_q));
	assign conv_end = (st_q == ST_CONV) && sar_tick && (ptr_q == last_ptr);
	assign acc_clr  = (st_q == ST_IDLE) && conv_start;

	// Sequencer
	always_comb begin
		st_d    = st_q;
		trial_d = trial_q;
		code_d  = code_q;
		ptr_d   = ptr_q;
		idx_d   = idx_q;
		len_d   = len_q;
		m8_d    = m8_q;
		m12_d   = m12_q;
		res_d   = res_q;
		case (st_q)
			ST_IDLE: begin
				if (conv_start) begin
					m8_d    = cfg_q[`SAR_CFG_8BIT_BIT];
					m12_d   = acc_q[`SAR_ACC_12BIT_BIT];
					len_d   = acc_q[`SAR_ACC_12BIT_BIT] ? burst_len : 7'h01;
					idx_d   = 7'h00;
					ptr_d   = `SAR_MSB_PTR;
					trial_d = 10'h200;
					st_d    = ST_CONV;
				end
			end
			ST_CONV: begin
				if (sar_tick) begin
					if (ptr_q == last_ptr) begin
						// Low bits were never trialled in eight-bit mode
						code_d  = dec;
						ptr_d   = `SAR_MSB_PTR;
						trial_d = 10'h200;
						if (idx_q + 7'h01 < len_q) begin
							idx_d = idx_q + 7'h01;
						end else begin
							st_d = ST_DONE;
						end
					end else begin
						ptr_d   = ptr_q - 4'h1;
						trial_d = dec | (10'h001 << (ptr_q - 4'h1));
					end
				end
			end
			ST_DONE: begin
				// Sum is right justified; single conversions are left justified
				res_d = m12_q ? acc_sum : {code_q, 6'h00};
				st_d  = ST_IDLE;
			end
			default: st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			st_q    <= ST_IDLE;
			trial_q <= '0;
			code_q  <= '0;
			ptr_q   <= `SAR_MSB_PTR;
			idx_q   <= 7'h00;
			len_q   <= 7'h01;
			m8_q    <= 1'b0;
			m12_q   <= 1'b0;
			res_q   <= 16'h0000;
		end else begin
			st_q    <= st_d;
			trial_q <= trial_d;
			code_q  <= code_d;
			ptr_q   <= ptr_d;
			idx_q   <= idx_d;
			len_q   <= len_d;
			m8_q    <= m8_d;
			m12_q   <= m12_d;
			res_q   <= res_d;
		end
	end

	sar_accum #(.W(ACC_W), .IW(10)) u_accum (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.clear   (acc_clr),
		.add_en  (conv_end),
		.add_val (dec),
		.sum     (acc_sum)
	);
	assign dac_code  = trial_q;
	assign ref_sel   = m12_q ? idx_q[1:0] : 2'h0;
	// Bit-reversed order steps the largest elements through rotations 0, 2, 1, 3
	assign dem_rot   = m12_q ? {idx_q[0], idx_q[1]} : 2'h0;
	assign conv_busy = (st_q != ST_IDLE);
	assign conv_done = (st_q == ST_DONE);
	// Register file; the factory offset is caught once after reset release
	always_comb begin
		cfg_d     = cfg_q;
		acc_d     = acc_q;
		temp_sensor_offset_d    = temp_sensor_offset_q;
		temp_sensor_offset_ld_d = 1'b1;
		rdata_d   = 8'h00;
		if (!temp_sensor_offset_ld_q) begin
			temp_sensor_offset_d = factory_offset;
		end
		if (sfr_wr && sfr_page == `SAR_PAGE_MAIN) begin
			if (sfr_addr == `SAR_ADDR_CFG) begin
				cfg_d = sfr_wdata;
			end
			if (sfr_addr == `SAR_ADDR_ACC) begin
				acc_d = sfr_wdata;
			end
		end
		if (sfr_rd) begin
			if (sfr_page == `SAR_PAGE_MAIN) begin
				case (sfr_addr)
					`SAR_ADDR_CFG:      rdata_d = cfg_q;
					`SAR_ADDR_ACC:      rdata_d = acc_q;
					`SAR_ADDR_RES_HIGH: rdata_d = res_q[15:8];
					`SAR_ADDR_RES_LOW:  rdata_d = res_q[7:0];
					default:            rdata_d = 8'h00;
				endcase
			end else if (sfr_page == `SAR_PAGE_FACTORY) begin
				case (sfr_addr)
					`SAR_ADDR_TEMP_SENSOR_OFFSET_HIGH: rdata_d = temp_sensor_offset_q[9:2];
					`SAR_ADDR_TEMP_SENSOR_OFFSET_LOW:  rdata_d = {temp_sensor_offset_q[1:0], 6'h00};
					default:             rdata_d = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cfg_q     <= `SAR_CFG_RESET;
			acc_q     <= `SAR_ACC_RESET;
			temp_sensor_offset_q    <= `SAR_TEMP_SENSOR_OFFSET_RESET;
			temp_sensor_offset_ld_q <= 1'b0;
			rdata_q   <= 8'h00;
		end else begin
			cfg_q     <= cfg_d;
			acc_q     <= acc_d;
			temp_sensor_offset_q    <= temp_sensor_offset_d;
			temp_sensor_offset_ld_q <= temp_sensor_offset_ld_d;
			rdata_q   <= rdata_d;
		end
	end
	assign sfr_rdata = rdata_q;
	// Helper counters for the checks below
	logic [4:0] tick_cnt_q;
	always_ff @(posedge ref_clk) begin
		if (!rst_b || st_q == ST_IDLE) begin
			tick_cnt_q <= 5'h00;
			conv_cnt_q <= 7'h00;
		end else begin
			tick_cnt_q <= conv_end ? 5'h00 : tick_cnt_q + 5'(sar_tick && st_q == ST_CONV);
			conv_cnt_q <= conv_cnt_q + 7'(conv_end);
		end
	end
	property p_len8;
		@(posedge ref_clk) disable iff (!rst_b)
		conv_end |-> (tick_cnt_q == (m8_q ? 5'd7 : 5'd9));
	endproperty
	a_len8: assert property (p_len8) else $error("conversion length wrong");
	property p_low2;
		@(posedge ref_clk) disable iff (!rst_b)
		conv_end && m8_q |=> code_q[1:0] == 2'h0;
	endproperty
	a_low2: assert property (p_low2) else $error("low bits set in 8-bit mode");
	property p_lowbyte;
		@(posedge ref_clk) disable iff (!rst_b)
		conv_done && m8_q && !m12_q |=> res_q[7:0] == 8'h00;
	endproperty
	a_lowbyte: assert property (p_lowbyte) else $error("low byte nonzero");
	property p_count;
		@(posedge ref_clk) disable iff (!rst_b)
		conv_done |-> conv_cnt_q == len_q;
	endproperty
	a_count: assert property (p_count) else $error("burst count wrong");
	property p_dem;
		@(posedge ref_clk) disable iff (!rst_b)
		conv_end && m12_q && st_d == ST_CONV |=> dem_rot != $past(dem_rot);
	endproperty
	a_dem: assert property (p_dem) else $error("element matching did not move");
	property p_max;
		@(posedge ref_clk) disable iff (!rst_b)
		conv_done && m12_q && len_q == 7'h04 |=> res_q <= `SAR_MAX_12BIT;
	endproperty
	a_max: assert property (p_max) else $error("12-bit sum above 4092");
	property p_sum;
		@(posedge ref_clk) disable iff (!rst_b)
		conv_done && m12_q |=> res_q == $past(acc_sum);
	endproperty
	a_sum: assert property (p_sum) else $error("result is not the burst sum");
	property p_temp_offset_high_byte;
		@(posedge ref_clk) disable iff (!rst_b)
		sfr_rd && sfr_page == `SAR_PAGE_FACTORY && sfr_addr == `SAR_ADDR_TEMP_SENSOR_OFFSET_HIGH
		|=> sfr_rdata == $past(temp_sensor_offset_q[9:2]);
	endproperty
	a_temp_offset_high_byte: assert property (p_temp_offset_high_byte) else $error("offset high byte wrong");
	property p_temp_offset_low_byte;
		@(posedge ref_clk) disable iff (!rst_b)
		sfr_rd && sfr_page == `SAR_PAGE_FACTORY && sfr_addr == `SAR_ADDR_TEMP_SENSOR_OFFSET_LOW
		|=> sfr_rdata[5:0] == 6'h00 && sfr_rdata[7:6] == $past(temp_sensor_offset_q[1:0]);
	endproperty
	a_temp_offset_low_byte: assert property (p_temp_offset_low_byte) else $error("offset low byte wrong");
endmodule

// ==== verif/sar_core_model.sv ====
// Comparator of the analogue converter core, with the input given as a code level.
// Assumes dac_code and ref_sel come straight from sar_ctrl.
`timescale 1ns/1ps
module sar_core_model (
	// Converter core
	input  wire logic [9:0] dac_code,
	input  wire logic [1:0] ref_sel,
	// Input level
	input  wire logic [9:0] vin,
	output logic            comp_in
);
	logic [10:0] lvl;

	// Each reference level moves the level one step; full scale saturates
	always_comb begin
		lvl = {1'b0, vin} + {9'h000, ref_sel};
		if (lvl > 11'h3ff)
			lvl = 11'h3ff;
		comp_in = lvl >= {1'b0, dac_code};
	end
endmodule

// ==== verif/test_sar_ctrl.sv ====
// Self-checking bench of sar_ctrl: registers, resolution modes, bursts, offset.
// Assumes the comparator model on the converter side and ticks every 8 cycles.
`timescale 1ns/1ps
`include "sar_regs.svh"
module test_sar_ctrl;
	logic        ref_clk, rst_b, sfr_wr, sfr_rd, conv_start, sar_tick, comp_in;
	logic        conv_busy, conv_done;
	logic [3:0]  sfr_page, seen;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, d;
	logic [9:0]  dac_code, factory_offset, vin;
	logic [1:0]  ref_sel, dem_rot;
	logic [15:0] ticks;
	logic [31:0] lfsr;
	int          fails, checked;

	sar_ctrl u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .sfr_page(sfr_page),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_rdata(sfr_rdata), .conv_start(conv_start), .sar_tick(sar_tick),
		.comp_in(comp_in), .dac_code(dac_code), .ref_sel(ref_sel), .dem_rot(dem_rot),
		.conv_busy(conv_busy), .conv_done(conv_done), .factory_offset(factory_offset));
	sar_core_model u_core (.dac_code(dac_code), .ref_sel(ref_sel), .vin(vin),
		.comp_in(comp_in));

	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Repeat field to burst length: 0 one conversion, then 4, 8, 16, 32, 64
	function automatic int burst_of(input logic [2:0] r);
		if (r == 3'h0)
			return 1;
		return (r >= 3'h5) ? 64 : (2 << r);
	endfunction

	function automatic logic [9:0] code_of(input logic [9:0] v, input int sel, input logic eb);
		logic [10:0] t;
		t = {1'b0, v} + 11'(sel);
		if (t > 11'h3ff)
			t = 11'h3ff;
		return eb ? {t[9:2], 2'b00} : t[9:0];
	endfunction

	// Single conversions are left justified, bursts are a right-justified sum
	function automatic logic [15:0] expect_res(input logic [9:0] v, input logic eb, tw,
		input int n);
		logic [15:0] s;
		s = 16'h0000;
		if (!tw)
			return {code_of(v, 0, eb), 6'h00};
		for (int i = 0; i < n; i++)
			s += 16'(code_of(v, i % 4, eb));
		return s;
	endfunction

	task automatic chk_byte(input logic [7:0] g, e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_word(input logic [15:0] g, e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic complete_run;
		if (fails == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Strobe held over one sampling edge; read data lands one cycle later
	task automatic bus(input logic wr, input logic [3:0] pg, input logic [7:0] a, wd);
		@(posedge ref_clk);
		#1;
		sfr_page = pg;
		sfr_addr = a;
		sfr_wdata = wd;
		sfr_wr = wr;
		sfr_rd = !wr;
		@(posedge ref_clk);
		#1;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask

	// Ticks are spaced wide enough for the comparator synchroniser to settle
	task automatic convert(input int n, bits, input logic tw);
		int         c;
		int         k;
		logic [7:0] x;
		ticks = 16'h0000;
		seen = 4'h0;
		@(posedge ref_clk);
		#1;
		conv_start = 1'b1;
		@(posedge ref_clk);
		#1;
		chk_byte({7'h00, conv_busy}, 8'h01);
		chk_word({6'h00, dac_code}, 16'h0200);
		for (c = 0; c < 20000 && conv_done !== 1'b1; c++) begin
			// A second start while busy must be ignored
			conv_start = (c == 3);
			sar_tick = (c % 8 == 7);
			if (sar_tick) begin
				k = int'(ticks) / bits;
				ticks++;
				seen[ref_sel] = 1'b1;
				x = tw ? {4'h0, 2'(k), k[0], k[1]} : 8'h00;
				chk_byte({4'h0, ref_sel, dem_rot}, x);
			end
			@(posedge ref_clk);
			#1;
		end
		sar_tick = 1'b0;
		if (c >= 20000) begin
			fails++;
			complete_run();
		end
		chk_word(ticks, 16'(n * bits));
		chk_byte({6'h00, conv_busy, conv_done}, 8'h03);
		@(posedge ref_clk);
		#1;
		chk_byte({6'h00, conv_busy, conv_done}, 8'h00);
	endtask

	task automatic run(input logic eb, tw, input logic [2:0] rep, input int n);
		logic [15:0] e;
		bus(1'b1, `SAR_PAGE_MAIN, `SAR_ADDR_CFG, {5'h00, eb, 2'h0});
		bus(1'b1, `SAR_PAGE_MAIN, `SAR_ADDR_ACC, {tw, 4'h0, rep});
		bus(1'b0, `SAR_PAGE_MAIN, `SAR_ADDR_ACC, 8'h00);
		chk_byte(d, {tw, 4'h0, rep});
		convert(n, eb ? 8 : 10, tw);
		chk_byte({4'h0, seen}, tw ? 8'h0f : 8'h01);
		e = expect_res(vin, eb, tw, n);
		bus(1'b0, `SAR_PAGE_MAIN, `SAR_ADDR_RES_HIGH, 8'h00);
		chk_byte(d, e[15:8]);
		// Result registers are read-only; this write must not land
		bus(1'b1, `SAR_PAGE_MAIN, `SAR_ADDR_RES_LOW, 8'h5a);
		bus(1'b0, `SAR_PAGE_MAIN, `SAR_ADDR_RES_LOW, 8'h00);
		chk_byte(d, e[7:0]);
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk; // Stands for the low-power oscillator
	end

	initial begin
		lfsr = step(32'h000131a4);
		rst_b = 1'b0;
		sfr_page = 4'h0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		conv_start = 1'b0;
		sar_tick = 1'b0;
		factory_offset = lfsr[9:0];
		vin = 10'h3ff;
		fails = 0;
		checked = 0;
		repeat (4) @(posedge ref_clk);
		#1;
		rst_b = 1'b1;
		bus(1'b0, `SAR_PAGE_FACTORY, `SAR_ADDR_TEMP_SENSOR_OFFSET_HIGH, 8'h00);
		chk_byte(d, factory_offset[9:2]);
		bus(1'b1, `SAR_PAGE_FACTORY, `SAR_ADDR_TEMP_SENSOR_OFFSET_LOW, 8'hff);
		bus(1'b0, `SAR_PAGE_FACTORY, `SAR_ADDR_TEMP_SENSOR_OFFSET_LOW, 8'h00);
		chk_byte(d, {factory_offset[1:0], 6'h00});
		bus(1'b0, `SAR_PAGE_MAIN, 8'h55, 8'h00);
		chk_byte(d, 8'h00);
		run(1'b0, 1'b1, 3'h1, 4);
		vin = 10'h000;
		run(1'b1, 1'b0, 3'h0, 1);
		// Consecutive bursts would double up if the sum were not cleared
		for (int k = 0; k < 16; k++) begin
			lfsr = step(lfsr);
			vin = lfsr[9:0];
			case (k % 4)
				0: run(1'b0, 1'b0, 3'h3, 1);
				1: run(1'b1, 1'b0, 3'h0, 1);
				2: run(1'b0, 1'b1, 3'h1, 4);
				default: run(lfsr[10], 1'b1, 3'(k / 4 + 2), burst_of(3'(k / 4 + 2)));
			endcase
		end
		// Reset after a burst start, before any SAR tick, drops all state and takes a fresh factory offset
		@(posedge ref_clk);
		#1;
		conv_start = 1'b1;
		@(posedge ref_clk);
		#1;
		conv_start = 1'b0;
		repeat (30) @(posedge ref_clk);
		#1;
		rst_b = 1'b0;
		lfsr = step(lfsr);
		factory_offset = lfsr[9:0];
		repeat (2) @(posedge ref_clk);
		#1;
		chk_word({dac_code, conv_busy, conv_done, ref_sel, dem_rot}, 16'h0000);
		chk_byte(sfr_rdata, 8'h00);
		rst_b = 1'b1;
		bus(1'b0, `SAR_PAGE_FACTORY, `SAR_ADDR_TEMP_SENSOR_OFFSET_HIGH, 8'h00);
		chk_byte(d, factory_offset[9:2]);
		bus(1'b0, `SAR_PAGE_MAIN, `SAR_ADDR_ACC, 8'h00);
		chk_byte(d, `SAR_ACC_RESET);
		run(1'b0, 1'b1, 3'h1, 4);
		complete_run();
	end
endmodule
